// *** verilog/cond_branch_unit.sv ***
// Behaviour
// RL1: imm less-or-equal: zero/negative jumps, else plus 4
// RL2: reg less-than: negative jumps by offset register
// RL3: imm less-than: negative jumps, else next word
// RL4: reg not-equal: nonzero jumps by offset register
// RL5: imm not-equal: nonzero jumps, else plus 4
// RL6: delay bit sits at position 6
// RL7: delay set: following instruction completes first
// RL8: delay clear and taken: following instruction squashed
// RL9: reg form latency 1, 2 or 3
// RL10: imm form 1 cycle, 2 taken with delay
// RL11: imm form 3 cycles without delay or mispredicted
// RL12: immediate sign extended from 16 to 32
// RL13: preceding prefix replaces the sign-extended operand
// RL14: immediate encoding fields and condition codes
// RL15: register encoding fields with zero tail
// RL16: only program counter changes, nothing else
// RL17: prefix gives upper half, one instruction only
// RL18: no prefix, branch or break in slot
// RL19: interrupts held until branch and slot complete
`timescale 1ns/100ps
`default_nettype none

module cond_branch_unit (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  output logic             issue_ready,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] issue_pc,
  input  wire logic [31:0] tested_source_register,
  input  wire logic [31:0] offset_register,
  input  wire logic        predict_valid,
  input  wire logic        predict_taken,
  input  wire logic        prefix_load,
  input  wire logic [15:0] prefix_value,
  input  wire logic        other_issue,
  input  wire logic        slot_done,
  output logic             done,
  output logic             taken,
  output logic [31:0]      next_pc,
  output logic             slot_allow,
  output logic             squash_next,
  output logic             irq_hold
);

  typedef struct packed {
    branch_pkg::phase_t phase;
    logic [1:0]         count;
    logic               taken;
    logic               delay;
    logic               slot_pending;
    logic [31:0]        next_pc;
    logic               prefix_valid;
    logic [15:0]        prefix_hi;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;
  decode_if    dif ();
  logic        accept;
  logic        cond_now;
  logic [31:0] operand;
  logic [1:0]  lat;

  function automatic logic [31:0] pc_add(input logic [31:0] base,
                                         input logic [31:0] off);
    pc_add = base + off;
  endfunction

  function automatic logic test_cond(input logic [3:0]  cond,
                                     input logic [31:0] value);
    case (cond)
      branch_pkg::COND_LE: test_cond = value[31] || (value == 32'h0);
      branch_pkg::COND_LT: test_cond = value[31];
      branch_pkg::COND_NE: test_cond = (value != 32'h0);
      default:             test_cond = 1'b0;
    endcase
  endfunction

  assign dif.instr = issue_instr;

  branch_decode u_decode (
    .dif (dif)
  );

  // handshake and result outputs; all are formed from flops alone, none from inputs
  assign issue_ready = (st.phase == branch_pkg::PH_IDLE);
  assign done        = (st.phase == branch_pkg::PH_BUSY) &&
                       (st.count == 2'h1);
  assign taken       = st.taken;
  assign next_pc     = st.next_pc; // RL16
  assign slot_allow  = st.delay; // RL7
  assign squash_next = st.taken && !st.delay; // RL8
  // a late interrupt would split the branch from its slot instruction
  assign irq_hold    = (st.phase == branch_pkg::PH_BUSY) ||
                       st.slot_pending; // RL19

  // operand, outcome and cycle count of the offered instruction
  always_comb begin
    accept   = issue_valid && issue_ready && dif.hit;
    cond_now = test_cond(dif.cond, tested_source_register); // RL1 RL3 RL5
    if (!dif.imm_form) begin
      operand = offset_register; // RL2 RL4
    end else if (st.prefix_valid) begin
      operand = {st.prefix_hi, dif.imm_field}; // RL13 RL17
    end else begin
      operand = {{16{dif.imm_field[15]}}, dif.imm_field}; // RL12
    end
    // prediction only speeds the immediate form; wrong guess costs most
    if (dif.imm_form && predict_valid) begin
      lat = (predict_taken == cond_now) ? branch_pkg::LAT_FAST
                                        : branch_pkg::LAT_SLOW; // RL10 RL11
    end else if (!cond_now) begin
      lat = branch_pkg::LAT_FAST; // RL9 RL10
    end else if (dif.delay) begin
      lat = branch_pkg::LAT_DELAY; // RL9 RL10
    end else begin
      lat = branch_pkg::LAT_SLOW; // RL9 RL11
    end
  end

  // sequencing, prefix tracking and slot hold
  always_comb begin
    next_st = st;
    unique case (st.phase)
      branch_pkg::PH_IDLE: begin
        if (accept) begin
          next_st.phase   = branch_pkg::PH_BUSY;
          next_st.count   = lat;
          next_st.taken   = cond_now;
          next_st.delay   = dif.delay;
          next_st.next_pc = cond_now ? pc_add(issue_pc, operand)
                                     : pc_add(issue_pc, branch_pkg::PC_STEP);
        end
      end
      branch_pkg::PH_BUSY: begin
        next_st.count = st.count - 2'h1;
        if (st.count == 2'h1) begin
          next_st.phase = branch_pkg::PH_IDLE;
        end
      end
    endcase
    // the slot instruction is trusted not to be another branch
    if (slot_done) begin
      next_st.slot_pending = 1'b0; // RL19
    end
    if (accept && dif.delay) begin
      next_st.slot_pending = 1'b1; // RL19
    end
    // any issued instruction uses up the prefix; a new load wins
    if ((issue_valid && issue_ready) || other_issue) begin
      next_st.prefix_valid = 1'b0; // RL17
    end
    if (prefix_load) begin
      next_st.prefix_valid = 1'b1;
      next_st.prefix_hi    = prefix_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st              <= '0;
      st.phase        <= branch_pkg::PH_IDLE;
      st.next_pc      <= branch_pkg::PC_RESET;
      st.prefix_hi    <= branch_pkg::PREFIX_RESET;
    end else begin
      st <= next_st;
    end
  end

  sequence s_one;
    done;
  endsequence

  sequence s_three;
    !done ##1 !done ##1 done;
  endsequence

  property p_le_imm;
    @(posedge ref_clk) disable iff (srst)
      (accept && dif.imm_form && dif.cond == 4'h3 && !st.prefix_valid &&
       (tested_source_register[31] || tested_source_register == 32'h0))
      |=> taken && next_pc == $past(issue_pc) +
          {{16{$past(issue_instr[15])}}, $past(issue_instr[15:0])};
  endproperty
  a_le_imm: assert property (p_le_imm) // RL1 RL12
    else $error("le imm target wrong");

  property p_lt_reg;
    @(posedge ref_clk) disable iff (srst)
      (accept && !dif.imm_form && dif.cond == 4'h2 &&
       tested_source_register[31])
      |=> taken && next_pc == $past(issue_pc) + $past(offset_register);
  endproperty
  a_lt_reg: assert property (p_lt_reg) // RL2
    else $error("lt reg target wrong");

  property p_lt_fall;
    @(posedge ref_clk) disable iff (srst)
      (accept && dif.imm_form && dif.cond == 4'h2 &&
       !tested_source_register[31])
      |=> !taken && next_pc == $past(issue_pc) + 32'h4;
  endproperty
  a_lt_fall: assert property (p_lt_fall) // RL3
    else $error("lt imm fell wrong");

  property p_ne_zero;
    @(posedge ref_clk) disable iff (srst)
      // a taken guess on a zero register is a mispredict and costs three
      (accept && dif.cond == 4'h1 && tested_source_register == 32'h0 &&
       !(dif.imm_form && predict_valid && predict_taken))
      |=> (!taken) and s_one;
  endproperty
  a_ne_zero: assert property (p_ne_zero) // RL4 RL9
    else $error("ne on zero taken");

  property p_ne_imm;
    @(posedge ref_clk) disable iff (srst)
      (accept && dif.imm_form && dif.cond == 4'h1 && st.prefix_valid &&
       tested_source_register != 32'h0)
      |=> taken && next_pc == $past(issue_pc) +
          {$past(st.prefix_hi), $past(issue_instr[15:0])};
  endproperty
  a_ne_imm: assert property (p_ne_imm) // RL5 RL13
    else $error("prefixed ne wrong");

  property p_squash;
    @(posedge ref_clk) disable iff (srst)
      accept |=> squash_next == (taken && !$past(issue_instr[25]));
  endproperty
  a_squash: assert property (p_squash) // RL6 RL8
    else $error("squash mismatch");

  property p_reg_slow;
    @(posedge ref_clk) disable iff (srst)
      (accept && !dif.imm_form && cond_now && !dif.delay) |=> s_three;
  endproperty
  a_reg_slow: assert property (p_reg_slow) // RL9
    else $error("reg not 3 cycles");

  property p_delay_two;
    @(posedge ref_clk) disable iff (srst)
      (accept && cond_now && dif.delay && !(dif.imm_form && predict_valid))
      |=> !done ##1 done;
  endproperty
  a_delay_two: assert property (p_delay_two) // RL10
    else $error("delay not 2");

  property p_mispredict;
    @(posedge ref_clk) disable iff (srst)
      (accept && dif.imm_form && predict_valid && predict_taken != cond_now)
      |=> s_three;
  endproperty
  a_mispredict: assert property (p_mispredict) // RL11
    else $error("miss not 3");

  property p_hold;
    @(posedge ref_clk) disable iff (srst)
      (accept && dif.delay) |=> irq_hold && slot_allow;
  endproperty
  a_hold: assert property (p_hold) else $error("irq not held"); // RL19

endmodule

`default_nettype wire

// *** verilog/branch_pkg.sv ***
package branch_pkg;

  // instruction field layout (bit 0 of the printed layout is bit 31 here)
  localparam int          OPC_LSB     = 26;
  localparam int          DELAY_BIT   = 25;
  localparam int          COND_LSB    = 21;
  localparam int          IMM_LSB     = 0;
  localparam int          ZERO_LSB    = 0;
  localparam int          ZERO_WIDTH  = 11;

  // major opcodes
  localparam logic [5:0]  OPC_REG     = 6'h27;
  localparam logic [5:0]  OPC_IMM     = 6'h2f;

  // condition codes handled by this unit
  localparam logic [3:0]  COND_NE     = 4'h1;
  localparam logic [3:0]  COND_LT     = 4'h2;
  localparam logic [3:0]  COND_LE     = 4'h3;

  // fall-through step and cycle counts
  localparam logic [31:0] PC_STEP     = 32'h0000_0004;
  localparam logic [1:0]  LAT_FAST    = 2'h1;
  localparam logic [1:0]  LAT_DELAY   = 2'h2;
  localparam logic [1:0]  LAT_SLOW    = 2'h3;

  // reset values
  localparam logic [31:0] PC_RESET    = 32'h0000_0000;
  localparam logic [15:0] PREFIX_RESET = 16'h0000;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_BUSY = 1'b1
  } phase_t;

endpackage

// *** verilog/decode_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface decode_if;
  logic [31:0] instr;
  logic        hit;
  logic        imm_form;
  logic        delay;
  logic [3:0]  cond;
  logic [15:0] imm_field;

  modport decoder (
    input  instr,
    output hit,
    output imm_form,
    output delay,
    output cond,
    output imm_field
  );

  modport core (
    output instr,
    input  hit,
    input  imm_form,
    input  delay,
    input  cond,
    input  imm_field
  );
endinterface

`default_nettype wire

// *** verilog/branch_decode.sv ***
`timescale 1ns/100ps
`default_nettype none

module branch_decode (
  decode_if.decoder dif
);

  logic [5:0] opcode;
  logic       cond_known;

  // field split and recognition of the three tests in both forms
  always_comb begin
    opcode        = dif.instr[branch_pkg::OPC_LSB +: 6];
    dif.imm_form  = (opcode == branch_pkg::OPC_IMM); // RL14
    dif.delay     = dif.instr[branch_pkg::DELAY_BIT]; // RL6
    dif.cond      = dif.instr[branch_pkg::COND_LSB +: 4]; // RL14
    dif.imm_field = dif.instr[branch_pkg::IMM_LSB +: 16];
    cond_known    = (dif.cond == branch_pkg::COND_LE) ||
                    (dif.cond == branch_pkg::COND_LT) ||
                    (dif.cond == branch_pkg::COND_NE);
    // register form insists on a clean zero tail, else not ours
    dif.hit       = cond_known && (dif.imm_form ||
                    ((opcode == branch_pkg::OPC_REG) &&
                     (dif.instr[branch_pkg::ZERO_LSB +: branch_pkg::ZERO_WIDTH]
                      == 11'h000))); // RL15
  end

endmodule

`default_nettype wire

// *** test/tb_conditional_branch_lt_le_ne.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_conditional_branch_lt_le_ne;
  logic        ref_clk, srst, issue_valid, issue_ready, predict_valid;
  logic        predict_taken, prefix_load, other_issue, slot_done, done;
  logic        taken, slot_allow, squash_next, irq_hold, f, d;
  logic [31:0] issue_instr, issue_pc, tested_source_register, v;
  logic [31:0] offset_register, next_pc;
  logic [15:0] prefix_value;
  logic [3:0]  c;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  integer      seed = 44;

  cond_branch_unit u_dut (.ref_clk(ref_clk), .srst(srst),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_instr(issue_instr), .issue_pc(issue_pc),
    .tested_source_register(tested_source_register),
    .offset_register(offset_register), .predict_valid(predict_valid),
    .predict_taken(predict_taken), .prefix_load(prefix_load),
    .prefix_value(prefix_value), .other_issue(other_issue),
    .slot_done(slot_done), .done(done), .taken(taken), .next_pc(next_pc),
    .slot_allow(slot_allow), .squash_next(squash_next), .irq_hold(irq_hold));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, want, seen);
    end
  endtask

  // encoding built here from the field layout, independent of the decoder
  function automatic logic [31:0] mk(input logic        imm,
                                     input logic        dl,
                                     input logic [3:0]  cc,
                                     input logic [15:0] lo);
    mk = {imm ? branch_pkg::OPC_IMM : branch_pkg::OPC_REG, dl, cc, 5'h03, lo};
  endfunction

  function automatic logic cond_ok(input logic [3:0] cc, input logic [31:0] x);
    case (cc)
      branch_pkg::COND_NE: cond_ok = x != 32'h0;
      branch_pkg::COND_LT: cond_ok = $signed(x) < 0;
      default:             cond_ok = $signed(x) <= 0;
    endcase
  endfunction

  task automatic pulse_prefix(input logic [15:0] val);
    prefix_load = 1'b1;
    prefix_value = val;
    @(negedge ref_clk);
    prefix_load = 1'b0;
    prefix_value = 16'($random(seed));
  endtask

  // offers one branch, then checks outcome, latency and interrupt hold-off
  task automatic branch(input logic [31:0] ins, input logic [31:0] x,
                        input logic [31:0] off, input logic pv, input logic pt,
                        input logic pfx, input logic [15:0] pval);
    logic        tk, dl, imm;
    logic [31:0] opnd, pc, lat, want;
    pc = $random(seed) & 32'hffff_fffc;
    imm = ins[31:26] == branch_pkg::OPC_IMM;
    dl = ins[branch_pkg::DELAY_BIT];
    tk = cond_ok(ins[24:21], x);
    opnd = !imm ? off : pfx ? {pval, ins[15:0]} : {{16{ins[15]}}, ins[15:0]};
    want = !tk ? 32'h1 : dl ? 32'h2 : 32'h3;
    if (imm && pv)
      want = (pt == tk) ? 32'h1 : 32'h3;
    issue_instr = ins;
    issue_pc = pc;
    tested_source_register = x;
    offset_register = off;
    predict_valid = pv;
    predict_taken = pt;
    issue_valid = 1'b1;
    check("issue_ready", issue_ready, 32'h1);
    @(negedge ref_clk);
    issue_valid = 1'b0;
    // operands are sampled at accept, so later garbage must not matter
    tested_source_register = ~x;
    offset_register = $random(seed);
    check("irq_hold", irq_hold, 32'h1);
    lat = 32'h1;
    while (done !== 1'b1 && lat < 32'h8) begin
      @(negedge ref_clk);
      lat++;
    end
    check("latency", lat, want);
    check("taken", taken, tk);
    want = tk ? pc + opnd : pc + branch_pkg::PC_STEP;
    check("next_pc", next_pc, want);
    check("slot_allow", slot_allow, dl);
    check("squash_next", squash_next, tk & !dl);
    @(negedge ref_clk);
    check("done", done, 32'h0);
    check("irq_hold", irq_hold, dl);
    // the slot holds no prefix or branch: nothing is offered until it ends
    if (dl) begin
      slot_done = 1'b1;
      @(negedge ref_clk);
      slot_done = 1'b0;
      check("irq_hold", irq_hold, 32'h0);
    end
  endtask

  initial begin
    {issue_valid, predict_valid, predict_taken, prefix_load} = 4'h0;
    {other_issue, slot_done} = 2'h0;
    {issue_instr, issue_pc, tested_source_register} = 96'h0;
    offset_register = 32'h0;
    prefix_value = 16'h0;
    srst = 1'b1;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    check("reset", {issue_ready, done, taken, slot_allow, squash_next,
                    irq_hold}, 32'h20);
    check("next_pc", next_pc, branch_pkg::PC_RESET);
    // sign extension boundary and prefix override
    branch(mk(1, 0, branch_pkg::COND_LE, 16'h8000), 0, 0, 0, 0, 0, 0);
    pulse_prefix(16'h1234);
    branch(mk(1, 1, branch_pkg::COND_NE, 16'h8000),
           5, 0, 0, 0, 1, 16'h1234);
    branch(mk(1, 0, branch_pkg::COND_NE, 16'hfff0), 5, 0, 0, 0, 0, 0);
    pulse_prefix(16'h00ff);
    other_issue = 1'b1;
    @(negedge ref_clk);
    other_issue = 1'b0;
    branch(mk(1, 0, branch_pkg::COND_LT, 16'h0040), -1, 0, 0, 0, 0, 0);
    // a register form with a nonzero tail is not a branch and eats the prefix
    pulse_prefix(16'h7777);
    issue_instr = mk(0, 0, branch_pkg::COND_LT, 16'h0001);
    issue_valid = 1'b1;
    @(negedge ref_clk);
    issue_valid = 1'b0;
    repeat (4) begin
      check("done", done, 32'h0);
      @(negedge ref_clk);
    end
    // taken against a not-taken guess, so a surviving prefix would show
    branch(mk(1, 0, branch_pkg::COND_LE, 16'h0100),
           0, 0, 1, 0, 0, 0);
    // random mix of forms, conditions, delay and prediction
    for (int i = 0; i < 120; i++) begin
      c = 4'({$random(seed)} % 3 + 1);
      case ({$random(seed)} % 4)
        0: v = 32'h0;
        1: v = 32'hffff_ffff;
        2: v = 32'h8000_0000;
        default: v = $random(seed);
      endcase
      f = 1'($random(seed));
      d = 1'($random(seed));
      branch(mk(f, d, c, f ? 16'($random(seed)) : 16'h2800), v, $random(seed),
             1'($random(seed)), 1'($random(seed)), 0, 0);
    end
    close_out();
  end
endmodule

`default_nettype wire
